//--- include/dbfx_pkg.sv
package dbfx_pkg;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [5:0] CONT_BYTE_W = 6'h08;
  localparam logic [5:0] CONT_HALF_W = 6'h10;
  localparam logic [5:0] CONT_WORD_W = 6'h20;

  localparam int EXT_SEL_BIT = 28;
  localparam int LSB_HI = 27;
  localparam int LSB_LO = 23;
  localparam int WID_HI = 22;
  localparam int WID_LO = 19;
  localparam int SLOT_BITS = 12;
  localparam int PERIPH_SLOTS = 129;

  localparam logic [31:0] EXT_STRIP_MASK = 32'hE007_FFFF;
  localparam logic [31:0] PLAIN_LO = 32'h4000_0000;
  localparam logic [31:0] PLAIN_HI = 32'h4007_FFFF;
  localparam logic [31:0] ILL1_LO = 32'h4008_0000;
  localparam logic [31:0] ILL1_HI = 32'h400F_EFFF;
  localparam logic [31:0] GPIO_STD_LO = 32'h400F_F000;
  localparam logic [31:0] GPIO_STD_HI = 32'h400F_FFFF;
  localparam logic [31:0] ILL2_LO = 32'h4010_0000;
  localparam logic [31:0] ILL2_HI = 32'h43FF_FFFF;
  localparam logic [31:0] DEC_LOGIC_LO = 32'h4400_0000;
  localparam logic [31:0] DEC_LOGIC_HI = 32'h4FFF_FFFF;
  localparam logic [31:0] DEC_FIELD_LO = 32'h5000_0000;
  localparam logic [31:0] DEC_FIELD_HI = 32'h5FFF_FFFF;
  localparam logic [31:0] GPIO_ALIAS_BASE = 32'h4000_F000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    RG_OTHER,
    RG_PLAIN,
    RG_GPIO,
    RG_ILLEGAL,
    RG_DEC_LOGIC,
    RG_DEC_FIELD
  } dbfx_region_t;

  typedef enum logic [2:0] {
    ST_PASS,
    ST_EXT_MASK,
    ST_EXT_OUT,
    ST_ERR_FIRST,
    ST_ERR_LAST
  } dbfx_state_t;

endpackage

//--- include/dbfx_ext_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dbfx_ext_if;
  logic [4:0] lsb;
  logic [3:0] wcode;
  logic [2:0] size;
  logic [1:0] lane;
  logic [31:0] rdata;
  logic [31:0] held;
  logic [31:0] masked;
  logic [31:0] justified;

  modport ctrl (
    output lsb, wcode, size, lane, rdata, held,
    input masked, justified
  );
  modport unit (
    input lsb, wcode, size, lane, rdata, held,
    output masked, justified
  );
endinterface
`default_nettype wire

//--- src/dbfx_extract_unit.sv
`timescale 1ns/1ns
`default_nettype none
module dbfx_extract_unit
  import dbfx_pkg::*;
(
  // Extract datapath
  dbfx_ext_if.unit ext
);
  logic [31:0] cont;
  logic [31:0] mask;
  logic [5:0] cwidth;
  logic [5:0] top;

  always_comb begin
    if (ext.size == HSIZE_BYTE) begin
      cont = (ext.rdata >> {ext.lane, 3'h0}) & 32'h0000_00FF;
      cwidth = CONT_BYTE_W;
    end else if (ext.size == HSIZE_HALF) begin
      cont = (ext.rdata >> {ext.lane[1], 4'h0}) & 32'h0000_FFFF;
      cwidth = CONT_HALF_W;
    end else begin
      cont = ext.rdata;
      cwidth = CONT_WORD_W;
    end
  end

  assign top = {1'b0, ext.lsb} + {2'h0, ext.wcode};

  for (genvar i = 0; i < 32; i++) begin : g_mask
    assign mask[i] = (6'(i) >= {1'b0, ext.lsb}) && (6'(i) <= top) && (6'(i) < cwidth);
  end

  assign ext.masked = cont & mask;
  assign ext.justified = ext.held >> ext.lsb;
endmodule
`default_nettype wire

//--- src/dbfx_bridge.sv
`timescale 1ns/1ns
`default_nettype none
module dbfx_bridge
  import dbfx_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Master side AHB
  input wire logic [31:0] m_haddr_i,
  input wire logic [1:0] m_htrans_i,
  input wire logic m_hwrite_i,
  input wire logic [2:0] m_hsize_i,
  input wire logic [31:0] m_hwdata_i,
  output logic [31:0] m_hrdata_o,
  output logic m_hready_o,
  output logic m_hresp_o,
  // Slave side AHB
  output logic [31:0] s_haddr_o,
  output logic [1:0] s_htrans_o,
  output logic s_hwrite_o,
  output logic [2:0] s_hsize_o,
  output logic [31:0] s_hwdata_o,
  output logic s_hready_o,
  output logic s_decor_o,
  input wire logic [31:0] s_hrdata_i,
  input wire logic slave_side_ready_i,
  input wire logic s_hresp_i
);

  // Address map decode of one master address.
  // peripheral slot map
  function automatic dbfx_region_t region_of(input logic [31:0] a);
    dbfx_region_t r;
    r = RG_OTHER;
    if (a >= PLAIN_LO && a <= PLAIN_HI) begin
      r = RG_PLAIN;
    end else if (a >= ILL1_LO && a <= ILL1_HI) begin
      r = RG_ILLEGAL;
    end else if (a >= GPIO_STD_LO && a <= GPIO_STD_HI) begin
      r = RG_GPIO;
    end else if (a >= ILL2_LO && a <= ILL2_HI) begin
      r = RG_ILLEGAL;
    end else if (a >= DEC_LOGIC_LO && a <= DEC_LOGIC_HI) begin
      r = RG_DEC_LOGIC;
    end else if (a >= DEC_FIELD_LO && a <= DEC_FIELD_HI) begin
      r = RG_DEC_FIELD;
    end
    return r;
  endfunction

  dbfx_state_t st_r;
  logic [4:0] lsb_r;
  logic [3:0] wcode_r;
  logic [2:0] size_r;
  logic [1:0] lane_r;
  logic [31:0] masked_r;

  dbfx_region_t region;
  logic active;
  logic accept;
  logic is_extract;
  logic is_illegal;

  dbfx_ext_if ext ();

  dbfx_extract_unit u_extract (
    .ext(ext)
  );

  assign region = region_of(m_haddr_i);
  assign active = m_htrans_i[1];
  assign accept = active && m_hready_o;

  assign is_extract = (region == RG_DEC_FIELD) && m_haddr_i[EXT_SEL_BIT] && !m_hwrite_i;

  assign is_illegal = (region == RG_ILLEGAL);

  assign ext.lsb = lsb_r;
  assign ext.wcode = wcode_r;
  assign ext.size = size_r;
  assign ext.lane = lane_r;
  assign ext.rdata = s_hrdata_i;
  assign ext.held = masked_r;

  always_comb begin
    case (st_r)
      ST_PASS: begin
        m_hready_o = slave_side_ready_i;
        m_hresp_o = s_hresp_i;
      end
      ST_EXT_MASK: begin
        m_hready_o = 1'b0;
        m_hresp_o = s_hresp_i;
      end
      ST_EXT_OUT: begin
        m_hready_o = 1'b1;
        m_hresp_o = 1'b0;
      end
      ST_ERR_FIRST: begin
        m_hready_o = 1'b0;
        m_hresp_o = 1'b1;
      end
      default: begin
        m_hready_o = 1'b1;
        m_hresp_o = 1'b1;
      end
    endcase
  end

  always_comb begin
    if (st_r == ST_EXT_OUT) begin
      m_hrdata_o = ext.justified;
    end else begin
      m_hrdata_o = s_hrdata_i;
    end
  end

  assign s_hready_o = m_hready_o;
  assign s_hwdata_o = m_hwdata_i;
  assign s_hsize_o = m_hsize_i;

  // Slave address phase; idle unless an accepted legal transfer.
  always_comb begin
    s_haddr_o = m_haddr_i;
    s_htrans_o = HTRANS_IDLE;
    s_hwrite_o = 1'b0;
    s_decor_o = 1'b0;
    if (accept && !is_illegal) begin
      s_htrans_o = m_htrans_i;
      s_hwrite_o = m_hwrite_i;
      if (is_extract) begin
        s_haddr_o = m_haddr_i & EXT_STRIP_MASK;
        s_hwrite_o = 1'b0;
      end else if (region == RG_GPIO) begin
        s_haddr_o = {GPIO_ALIAS_BASE[31:SLOT_BITS], m_haddr_i[SLOT_BITS-1:0]};
      end else if (region == RG_DEC_LOGIC || region == RG_DEC_FIELD) begin
        s_decor_o = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lsb_r <= 5'h00;
      wcode_r <= 4'h0;
      size_r <= 3'h0;
      lane_r <= 2'h0;
    end else if (accept && is_extract) begin
      lsb_r <= m_haddr_i[LSB_HI:LSB_LO];
      wcode_r <= m_haddr_i[WID_HI:WID_LO];
      size_r <= m_hsize_i;
      lane_r <= m_haddr_i[1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      masked_r <= RDATA_RST;
    end else if (st_r == ST_EXT_MASK && slave_side_ready_i) begin
      masked_r <= ext.masked;
    end
  end

  // Sequencer for the extract pipeline and the error response.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_PASS;
    end else begin
      case (st_r)
        ST_EXT_MASK: begin
          if (slave_side_ready_i && s_hresp_i) begin
            st_r <= ST_PASS;
          end else if (slave_side_ready_i) begin
            st_r <= ST_EXT_OUT;
          end
        end
        ST_ERR_FIRST: begin
          st_r <= ST_ERR_LAST;
        end
        default: begin
          if (accept && is_illegal) begin
            st_r <= ST_ERR_FIRST;
          end else if (accept && is_extract) begin
            st_r <= ST_EXT_MASK;
          end else begin
            st_r <= ST_PASS;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ext_start;
    accept && is_extract;
  endsequence

  sequence s_err_start;
    accept && is_illegal;
  endsequence

  sequence s_err_resp;
    (m_hresp_o && !m_hready_o) ##1 (m_hresp_o && m_hready_o);
  endsequence

  a_ext_read_only:
    assert property (s_ext_start |-> s_htrans_o[1] && !s_hwrite_o)
      else $error("Field extract forwarded as a write.");

  a_ext_strip_addr:
    assert property (s_ext_start |-> s_haddr_o == (m_haddr_i & EXT_STRIP_MASK)
                     && s_hsize_o == m_hsize_i)
      else $error("Field extract address not stripped.");

  a_ext_idle_slot:
    assert property (s_ext_start |=> s_htrans_o == HTRANS_IDLE)
      else $error("Second address phase not idle.");

  a_ext_stall_master:
    assert property (s_ext_start |=> !m_hready_o)
      else $error("Master not stalled in mask cycle.");

  a_ext_capture:
    assert property (s_ext_start |=> lsb_r == $past(m_haddr_i[LSB_HI:LSB_LO])
                     && wcode_r == $past(m_haddr_i[WID_HI:WID_LO]))
      else $error("Decoration fields not captured.");

  a_ext_result:
    assert property ((st_r == ST_EXT_MASK && slave_side_ready_i && !s_hresp_i)
                     |=> m_hready_o && !m_hresp_o
                     && m_hrdata_o == ($past(ext.masked) >> lsb_r))
      else $error("Justified extract data not returned.");

  a_wait_passthru:
    assert property ((st_r == ST_EXT_MASK && !slave_side_ready_i)
                     |=> st_r == ST_EXT_MASK && !m_hready_o)
      else $error("Slave wait state not passed back.");

  a_err_two_cycle:
    assert property (s_err_start |=> s_err_resp)
      else $error("Illegal access lacks two-cycle error.");

  a_err_not_fwd:
    assert property (s_err_start |-> s_htrans_o == HTRANS_IDLE)
      else $error("Illegal access forwarded to slave.");

  a_gpio_remap:
    assert property ((accept && region == RG_GPIO)
                     |-> s_haddr_o[31:SLOT_BITS] == GPIO_ALIAS_BASE[31:SLOT_BITS]
                     && s_htrans_o == m_htrans_i && !s_decor_o)
      else $error("Standard GPIO address not mapped to its slot.");

  a_plain_pass:
    assert property ((accept && region == RG_PLAIN)
                     |-> s_haddr_o == m_haddr_i && s_htrans_o == m_htrans_i
                     && s_hwrite_o == m_hwrite_i && !s_decor_o)
      else $error("Plain peripheral access altered.");

  a_bit19_address:
    assert property ((accept && region == RG_DEC_LOGIC)
                     |-> s_haddr_o[WID_LO] == m_haddr_i[WID_LO] && s_decor_o)
      else $error("Bit 19 not kept for decorated logic op.");

  a_ext_no_wback:
    assert property (st_r == ST_EXT_MASK |-> !s_hwrite_o)
      else $error("Write issued during field extract.");

  a_ext_hold_idle:
    assert property (st_r == ST_EXT_MASK |-> s_htrans_o == HTRANS_IDLE)
      else $error("Slave address phase not idle while masking.");

  a_ext_out_ready:
    assert property (st_r == ST_EXT_OUT |-> m_hready_o && !m_hresp_o)
      else $error("Extract result cycle does not complete.");

  a_ext_zero_fill:
    assert property (st_r == ST_EXT_OUT
                     |-> (m_hrdata_o >> ({1'b0, wcode_r} + 5'h01)) == 32'h0000_0000)
      else $error("Extract result not zero filled.");

  a_byte_in_cont:
    assert property ((st_r == ST_EXT_OUT && size_r == HSIZE_BYTE)
                     |-> (masked_r >> CONT_BYTE_W) == 32'h0000_0000)
      else $error("Byte extract reaches past its container.");

  a_half_in_cont:
    assert property ((st_r == ST_EXT_OUT && size_r == HSIZE_HALF)
                     |-> (masked_r >> CONT_HALF_W) == 32'h0000_0000)
      else $error("Halfword extract reaches past its container.");

  a_mask_low_zero:
    assert property (st_r == ST_EXT_OUT
                     |-> (masked_r & ((32'h0000_0001 << lsb_r) - 32'h0000_0001)) == 32'h0000_0000)
      else $error("Mask kept bits below the field.");

  a_wait_release:
    assert property ((st_r == ST_EXT_MASK && slave_side_ready_i && !s_hresp_i)
                     |=> st_r == ST_EXT_OUT)
      else $error("Extract did not resume after slave ready.");

  a_slave_err_pass:
    assert property (st_r == ST_EXT_MASK |-> m_hresp_o == s_hresp_i)
      else $error("Slave response not passed back during extract.");

  a_err_no_decor:
    assert property (s_err_start |-> !s_decor_o && !s_hwrite_o)
      else $error("Illegal access marked toward slaves.");

  a_field_wr_decor:
    assert property ((accept && region == RG_DEC_FIELD && m_hwrite_i)
                     |-> s_decor_o && s_haddr_o == m_haddr_i && s_hwrite_o)
      else $error("Field insert store not handed on.");

  a_size_kept:
    assert property ((accept && !is_illegal) |-> s_hsize_o == m_hsize_i)
      else $error("Access size changed on the slave bus.");

  a_ext_lane_cap:
    assert property (s_ext_start |=> size_r == $past(m_hsize_i)
                     && lane_r == $past(m_haddr_i[1:0]))
      else $error("Container size or lane not captured.");

endmodule
`default_nettype wire

//--- verif/dbfx_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbfx_slave_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slave bus
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  // Scenario control and observation
  input wire logic [31:0] rd_val_i,
  input wire logic [3:0] waits_i,
  output logic [31:0] last_addr_o,
  output logic [2:0] last_size_o,
  output int xfer_cnt_o,
  output int wr_cnt_o
);
  logic pend_r;
  logic [3:0] cnt_r;

  assign hreadyout_o = !(pend_r && cnt_r != 4'h0);
  // Outside a valid data phase the bus shows the inverse, so stale data cannot match.
  assign hrdata_o = (pend_r && cnt_r == 4'h0) ? rd_val_i : ~rd_val_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      cnt_r <= 4'h0;
      last_addr_o <= 32'h0000_0000;
      last_size_o <= 3'h0;
      xfer_cnt_o <= 0;
      wr_cnt_o <= 0;
    end else begin
      if (pend_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (pend_r && hready_i) begin
        pend_r <= 1'b0;
      end
      if (htrans_i[1] && hready_i) begin
        pend_r <= 1'b1;
        cnt_r <= waits_i;
        last_addr_o <= haddr_i;
        last_size_o <= hsize_i;
        xfer_cnt_o <= xfer_cnt_o + 1;
        wr_cnt_o <= wr_cnt_o + (hwrite_i ? 1 : 0);
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import dbfx_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] m_haddr = 32'h0000_0000;
  logic [1:0] m_htrans = HTRANS_IDLE;
  logic [2:0] m_hsize = 3'h2;
  logic [31:0] rd_val = 32'h0000_0000;
  logic [3:0] waits = 4'h0;
  logic m_hwrite = 1'b0;
  logic [31:0] m_hwdata = 32'h0000_0000;
  logic s_decor, decor_seen;
  logic [31:0] m_hrdata_o, s_haddr_o, s_hwdata_o, s_hrdata, last_addr;
  logic [1:0] s_htrans_o;
  logic [2:0] s_hsize_o, last_size;
  logic m_hready_o, m_hresp_o, s_hwrite_o, s_hready_o, s_ready;
  int xfer_cnt, wr_cnt;
  int fail_count = 0;
  int checks_done = 0;

  localparam logic [31:0] EXT_A [5] = '{32'h5238_F004, 32'h5FF8_0100, 32'h5318_0101,
    32'h5638_0202, 32'h5180_0008};
  localparam logic [2:0] EXT_S [5] = '{3'h2, 3'h2, 3'h0, 3'h1, 3'h2};
  localparam logic [31:0] EXT_D [5] = '{32'hA5C3_5AF0, 32'h8000_0001, 32'h0000_C300,
    32'hF123_0000, 32'h0000_0008};
  localparam logic [3:0] EXT_W [5] = '{4'h0, 4'h2, 4'h0, 4'h1, 4'h0};

  dbfx_bridge i_dbfx_bridge (.clk_i(clk_i), .rst_i(rst_i), .m_haddr_i(m_haddr),
    .m_htrans_i(m_htrans), .m_hwrite_i(m_hwrite), .m_hsize_i(m_hsize),
    .m_hwdata_i(m_hwdata), .m_hrdata_o(m_hrdata_o), .m_hready_o(m_hready_o),
    .m_hresp_o(m_hresp_o), .s_haddr_o(s_haddr_o), .s_htrans_o(s_htrans_o),
    .s_hwrite_o(s_hwrite_o), .s_hsize_o(s_hsize_o), .s_hwdata_o(s_hwdata_o),
    .s_hready_o(s_hready_o), .s_decor_o(s_decor), .s_hrdata_i(s_hrdata),
    .slave_side_ready_i(s_ready), .s_hresp_i(1'b0));

  dbfx_slave_model i_dbfx_slave_model (.clk_i(clk_i), .rst_i(rst_i), .haddr_i(s_haddr_o),
    .htrans_i(s_htrans_o), .hwrite_i(s_hwrite_o), .hsize_i(s_hsize_o),
    .hready_i(s_hready_o), .hrdata_o(s_hrdata), .hreadyout_o(s_ready),
    .rd_val_i(rd_val), .waits_i(waits), .last_addr_o(last_addr),
    .last_size_o(last_size), .xfer_cnt_o(xfer_cnt), .wr_cnt_o(wr_cnt));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  function automatic logic [31:0] exp_ext(input logic [31:0] a, input logic [2:0] sz,
    input logic [31:0] d);
    logic [31:0] c;
    logic [4:0] w;
    w = {1'b0, a[22:19]} + 5'h01;
    if (sz == HSIZE_BYTE) c = (d >> {a[1:0], 3'h0}) & 32'h0000_00FF;
    else if (sz == HSIZE_HALF) c = (d >> {a[1], 4'h0}) & 32'h0000_FFFF;
    else c = d;
    return (c >> a[27:23]) & ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction

  // One read; the answer is taken just before the edge that completes it.
  task automatic ahb_rd(input logic [31:0] a, input logic [2:0] sz, output logic [31:0] d,
    output logic r, output int stalls);
    int n;
    n = 0;
    stalls = 0;
    m_haddr = a;
    m_hsize = sz;
    m_htrans = 2'h2;
    @(negedge clk_i);
    while (m_hready_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    decor_seen = s_decor;
    @(posedge clk_i);
    #1;
    m_htrans = HTRANS_IDLE;
    @(negedge clk_i);
    while (m_hready_o !== 1'b1 && n < 50) begin
      chk(s_htrans_o === HTRANS_IDLE, "second transfer during stall");
      stalls++;
      n++;
      @(negedge clk_i);
    end
    d = m_hrdata_o;
    r = m_hresp_o;
    chk(n < 50, "no ready from bridge");
    @(posedge clk_i);
    #1;
  endtask

  task automatic t_extract();
    logic [31:0] d;
    logic r;
    int st, c0, w0;
    for (int i = 0; i < 5; i++) begin
      rd_val = EXT_D[i];
      waits = EXT_W[i];
      c0 = xfer_cnt;
      w0 = wr_cnt;
      ahb_rd(EXT_A[i], EXT_S[i], d, r, st);
      chk(d === exp_ext(EXT_A[i], EXT_S[i], EXT_D[i]), "extract data");
      chk(last_addr === (EXT_A[i] & EXT_STRIP_MASK), "stripped address");
      chk(last_size === EXT_S[i], "size changed");
      chk(decor_seen === 1'b0, "extract marked as decorated");
      chk(xfer_cnt == c0 + 1 && wr_cnt == w0, "extra slave access");
      chk(st == 1 + EXT_W[i] && r === 1'b0, "stall count");
    end
    waits = 4'h0;
    $display("extract test done");
  endtask

  task automatic t_plain();
    localparam logic [31:0] PA [3] = '{32'h4000_1234, 32'h400F_F010, 32'h4400_0010};
    localparam logic [31:0] PS [3] = '{32'h4000_1234, 32'h4000_F010, 32'h4400_0010};
    logic [31:0] d;
    logic r;
    int st;
    for (int i = 0; i < 3; i++) begin
      rd_val = 32'h1357_9BDF ^ PA[i];
      ahb_rd(PA[i], 3'h2, d, r, st);
      chk(last_addr === PS[i], "forwarded address");
      chk(d === (32'h1357_9BDF ^ PA[i]) && r === 1'b0 && st == 0, "plain answer");
      chk(decor_seen === (i == 2), "decorated flag");
    end
    $display("plain test done");
  endtask

  task automatic t_illegal();
    localparam logic [31:0] IA [4] = '{32'h4008_0000, 32'h400F_EFFC, 32'h4010_0000,
      32'h43FF_FFFC};
    logic [31:0] d;
    logic r;
    int st, c0;
    for (int i = 0; i < 4; i++) begin
      c0 = xfer_cnt;
      ahb_rd(IA[i], 3'h2, d, r, st);
      chk(r === 1'b1 && st == 1, "error response");
      chk(xfer_cnt == c0, "illegal access forwarded");
    end
    $display("illegal test done");
  endtask

  task automatic t_write();
    localparam logic [31:0] WA [3] = '{32'h4000_1234, 32'h4408_0010, 32'h5238_F004};
    logic [31:0] d;
    logic r;
    int st, w0;
    m_hwrite = 1'b1;
    for (int i = 0; i < 3; i++) begin
      w0 = wr_cnt;
      m_hwdata = 32'h2468_ACE0 ^ WA[i];
      ahb_rd(WA[i], 3'h2, d, r, st);
      chk(last_addr === WA[i] && wr_cnt == w0 + 1, "write forwarded");
      chk(decor_seen === (i != 0) && r === 1'b0 && st == 0, "write decor flag");
      chk(s_hwdata_o === (32'h2468_ACE0 ^ WA[i]), "write data");
    end
    m_hwrite = 1'b0;
    $display("write test done");
  endtask

  task automatic finish_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    t_extract();
    t_plain();
    t_illegal();
    t_write();
    finish_test();
  end
endmodule
`default_nettype wire
